// *** hw/call_progress_pwm_output.sv ***
// Purpose: Call-progress monitor pin driver with AHB-Lite register slave.
// Assumes: Voice samples come from logic on CLOCK with a one-cycle strobe.
// Notes: Zero-wait slave, always OKAY; unmapped reads return zero.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module call_progress_pwm_output
  import cpm_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16
)
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Voice paths, read only
  input wire logic SAMPLE_STROBE,
  input wire logic signed [SAMPLE_W-1:0] RX_SAMPLE,
  input wire logic signed [SAMPLE_W-1:0] TX_SAMPLE,
  // Monitor pin
  output logic MONITOR_AUDIO_PIN
);

  // Saturation and the offset-binary mapping need a sign bit plus at least one magnitude bit.
  if (SAMPLE_W < 2 || SAMPLE_W > 24)
  begin : g_bad_sample_w
    $error("SAMPLE_W out of range");
  end

  // Register file and bus slave.
  bus_phase_t phase_q, phase_d;
  monitor_cfg_t cfg_q, cfg_d;
  logic [31:0] rdata_d;
  logic active;

  always_comb
  begin
    phase_d = '0;
    cfg_d = cfg_q;
    rdata_d = '0;
    if (phase_q.valid && phase_q.write)
    begin
      unique case (phase_q.index)
        IDX_PWM_CTRL:
        begin
          cfg_d.pwm_on = HWDATA[PWM_ON_BIT];
          cfg_d.fmt = HWDATA[FMT_LSB +: 2];
        end
        IDX_IRQ_CTRL: cfg_d.irq_sel = HWDATA[IRQ_SEL_BIT];
        IDX_RX_ATT: cfg_d.rx_att = HWDATA[7:0];
        IDX_TX_ATT: cfg_d.tx_att = HWDATA[7:0];
        default: ;
      endcase
    end
    if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HADDR[31:10] == '0)
    begin
      phase_d.valid = 1'b1;
      phase_d.write = HWRITE;
      phase_d.index = HADDR[9:2];
      if (!HWRITE)
      begin
        unique case (HADDR[9:2])
          IDX_PWM_CTRL:
          begin
            rdata_d[PWM_ON_BIT] = cfg_q.pwm_on;
            rdata_d[FMT_LSB +: 2] = cfg_q.fmt;
          end
          IDX_IRQ_CTRL: rdata_d[IRQ_SEL_BIT] = cfg_q.irq_sel;
          IDX_RX_ATT: rdata_d[7:0] = cfg_q.rx_att;
          IDX_TX_ATT: rdata_d[7:0] = cfg_q.tx_att;
          IDX_STATUS: rdata_d[2:0] = {cfg_q.fmt, active};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      phase_q <= '0;
      cfg_q <= '{irq_sel: 1'b0, pwm_on: 1'b0, fmt: FMT_DELTA_SIGMA,
                 rx_att: ATT_RESET, tx_att: ATT_RESET};
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cfg_q <= cfg_d;
      // Launched at the address-phase edge so the word stands for the whole data phase.
      HRDATA <= rdata_d;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Reserved code 11 keeps the pin quiet rather than guessing a format.
  assign active = !cfg_q.irq_sel && cfg_q.pwm_on && cfg_q.fmt != FMT_RESERVED;

  // Monitor mix. Samples are only read here, so the line paths stay as they are.
  localparam int unsigned PROD_W = SAMPLE_W + 9;
  logic signed [SAMPLE_W-1:0] mix_q, mix_d;
  logic signed [PROD_W:0] sum;
  logic signed [PROD_W-8:0] scaled;

  always_comb
  begin
    sum = (PROD_W+1)'(RX_SAMPLE * $signed({1'b0, cfg_q.rx_att}))
        + (PROD_W+1)'(TX_SAMPLE * $signed({1'b0, cfg_q.tx_att}));
    scaled = sum[PROD_W:8];
    mix_d = mix_q;
    if (SAMPLE_STROBE)
    begin
      if (scaled > $signed({{3{1'b0}}, {(SAMPLE_W-1){1'b1}}}))
        mix_d = {1'b0, {(SAMPLE_W-1){1'b1}}};
      else if (scaled < $signed({{3{1'b1}}, {(SAMPLE_W-1){1'b0}}}))
        mix_d = {1'b1, {(SAMPLE_W-1){1'b0}}};
      else
        mix_d = scaled[SAMPLE_W-1:0];
    end
  end

  // Output generators.
  logic [PWM_W-1:0] cnt_q, cnt_d, duty_q, duty_d, lo;
  logic [SAMPLE_W-1:0] level;
  logic [SAMPLE_W:0] acc_q, acc_d;
  logic [SAMPLE_W+PWM_W-1:0] duty_full;
  logic pin_d;

  always_comb
  begin
    level = {~mix_q[SAMPLE_W-1], mix_q[SAMPLE_W-2:0]};
    duty_full = (SAMPLE_W+PWM_W)'(level) * (SAMPLE_W+PWM_W)'(PWM_PERIOD);
    cnt_d = (cnt_q == PWM_W'(PWM_PERIOD - 1)) ? '0 : cnt_q + 1'b1;
    // Duty is taken only at the period start so a pulse is never cut short.
    duty_d = (cnt_q == PWM_W'(PWM_PERIOD - 1)) ? duty_full[SAMPLE_W +: PWM_W] : duty_q;
    lo = (PWM_W'(PWM_PERIOD) - duty_q) >> 1;
    acc_d = {1'b0, acc_q[SAMPLE_W-1:0]} + {1'b0, level};
    pin_d = 1'b0;
    if (active)
    begin
      unique case (cfg_q.fmt)
        FMT_DELTA_SIGMA: pin_d = acc_d[SAMPLE_W];
        FMT_RZ_PWM: pin_d = cnt_q < duty_q;
        FMT_BAL_PWM: pin_d = cnt_q >= lo && cnt_q < lo + duty_q;
        default: pin_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mix_q <= '0;
      cnt_q <= '0;
      duty_q <= '0;
      acc_q <= '0;
      MONITOR_AUDIO_PIN <= 1'b0;
    end
    else
    begin
      mix_q <= mix_d;
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      acc_q <= acc_d;
      MONITOR_AUDIO_PIN <= pin_d;
    end
  end

  // Checks.
  chk_output_gate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !active |=> !MONITOR_AUDIO_PIN)
    else $error("monitor pin high while output disabled");

  chk_reserved_quiet: assert property (@(posedge CLOCK) disable iff (!RST_N)
    cfg_q.fmt == FMT_RESERVED |=> !MONITOR_AUDIO_PIN)
    else $error("monitor pin high with reserved format");

  chk_mute_both: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SAMPLE_STROBE && cfg_q.rx_att == 8'h00 && cfg_q.tx_att == 8'h00 |=> mix_q == '0)
    else $error("muted paths left a nonzero mix");

  chk_half_scale: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SAMPLE_STROBE && cfg_q.rx_att == 8'h80 && cfg_q.tx_att == 8'h00
    |=> mix_q == ($past(RX_SAMPLE) >>> 1))
    else $error("receive scaling not linear");

  chk_rz_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_RZ_PWM && cnt_q == '0 && duty_q != '0 |=> MONITOR_AUDIO_PIN)
    else $error("return-to-zero pulse missing at period start");

  chk_rz_tail: assert property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_RZ_PWM && cnt_q == PWM_W'(PWM_PERIOD - 1)
    && duty_q < PWM_W'(PWM_PERIOD) |=> !MONITOR_AUDIO_PIN)
    else $error("return-to-zero pulse high at period end");

  chk_bal_centre: assert property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_BAL_PWM && cnt_q == lo && duty_q != '0 |=> MONITOR_AUDIO_PIN)
    else $error("balanced pulse missing at its start");

  chk_bus_okay: assert property (@(posedge CLOCK) disable iff (!RST_N)
    HREADYOUT && !HRESP)
    else $error("bus slave stalled or errored");

  cov_delta_sigma: cover property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_DELTA_SIGMA ##1 MONITOR_AUDIO_PIN);
  cov_rz_pwm: cover property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_RZ_PWM ##1 $fell(MONITOR_AUDIO_PIN));
  cov_balanced: cover property (@(posedge CLOCK) disable iff (!RST_N)
    active && cfg_q.fmt == FMT_BAL_PWM ##1 $rose(MONITOR_AUDIO_PIN));
  cov_half_scale: cover property (@(posedge CLOCK) disable iff (!RST_N)
    SAMPLE_STROBE && cfg_q.rx_att == 8'h80 && cfg_q.tx_att == 8'h00);

endmodule // call_progress_pwm_output

// *** hw/cpm_pkg.sv ***
// Purpose: Constants and types for the call-progress monitor output block.
// Assumes: 10 MHz clock, AHB-Lite register access with 32-bit data.
// Notes: Register offsets are indices; the byte address is four times the index.
// Contract
// - The monitor output runs only with irq_output_select 0, monitor_pwm_on 1 and a format other than 11.
// - Receive and transmit shares of the monitor output scale linearly with their attenuation.
// - An attenuation register of all zeros fully mutes that path's share.
// - Attenuation touches only the monitor output, never the line signals.
// - The format field at bits 5:4 picks delta-sigma, 32 kHz return-to-zero or balanced PWM.
package cpm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned PWM_HZ = 32_000;
  localparam int unsigned PWM_PERIOD = CLK_HZ / PWM_HZ;
  localparam int unsigned PWM_W = 9;
  localparam logic [7:0] IDX_PWM_CTRL = 8'h01;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h02;
  localparam logic [7:0] IDX_RX_ATT = 8'h14;
  localparam logic [7:0] IDX_TX_ATT = 8'h15;
  localparam logic [7:0] IDX_STATUS = 8'h16;
  localparam int unsigned PWM_ON_BIT = 3;
  localparam int unsigned FMT_LSB = 4;
  localparam int unsigned IRQ_SEL_BIT = 7;
  localparam logic [7:0] ATT_RESET = 8'h00;
  localparam logic [1:0] FMT_DELTA_SIGMA = 2'h0;
  localparam logic [1:0] FMT_RZ_PWM = 2'h1;
  localparam logic [1:0] FMT_BAL_PWM = 2'h2;
  localparam logic [1:0] FMT_RESERVED = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } bus_phase_t;

  typedef struct packed {
    logic irq_sel;
    logic pwm_on;
    logic [1:0] fmt;
    logic [7:0] rx_att;
    logic [7:0] tx_att;
  } monitor_cfg_t;
endpackage

// *** test/speaker_model.sv ***
// Purpose: Speaker side of the monitor pin, integrating the drive it hears.
// Assumes: One sample per clock edge is enough to judge the average drive.
// Notes: It only listens, since the pin carries nothing back to the block.
`timescale 1ns/1ps
module speaker_model
(
  // Clock and pin
  input wire logic clk,
  input wire logic pin,
  // Running count of high cycles
  output int unsigned highs
);
  initial highs = 0;
  always @(posedge clk)
  begin
    highs <= highs + ((pin === 1'b1) ? 1 : 0);
  end
endmodule // speaker_model

// *** test/call_progress_pwm_output_tb.sv ***
// Purpose: Random and corner tests of the monitor pin block over AHB-Lite.
// Assumes: The slave answers when it raises HREADYOUT; the bench waits for it in both phases.
// Notes: Pin averages are judged over three whole periods with a slack of three.
`timescale 1ns/1ps
module call_progress_pwm_output_tb;
  import cpm_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 1, hwrite = 0, strobe = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, r;
  logic signed [15:0] rx = 16'sh0, tx = 16'sh0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, pin;
  int unsigned highs, n_fail = 0, compares = 0;
  call_progress_pwm_output call_progress_pwm_output_inst (.CLOCK(clk), .RST_N(rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SAMPLE_STROBE(strobe), .RX_SAMPLE(rx), .TX_SAMPLE(tx),
    .MONITOR_AUDIO_PIN(pin));
  speaker_model speaker_model_inst (.clk(clk), .pin(pin), .highs(highs));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  // Offset-binary level of the mix, saturated the way the pin can express it.
  function automatic int lvl(int a, int b, int ra, int ta);
    int m;
    m = (a * ra + b * ta) >>> 8;
    if (m > 32767) m = 32767;
    if (m < -32768) m = -32768;
    return m + 32768;
  endfunction
  task automatic run(input logic irq, input logic on, input logic [1:0] fmt,
    input logic [7:0] ra, input logic [7:0] ta);
    int e, d;
    ahb(IDX_IRQ_CTRL, 1'b1, {24'h0, irq, 7'h0});
    ahb(IDX_PWM_CTRL, 1'b1, {26'h0, fmt, on, 3'h0});
    ahb(IDX_RX_ATT, 1'b1, {24'h0, ra});
    ahb(IDX_TX_ATT, 1'b1, {24'h0, ta});
    ahb(IDX_PWM_CTRL, 1'b0, 32'h0);
    check(rdata, {26'h0, fmt, on, 3'h0});
    ahb(IDX_IRQ_CTRL, 1'b0, 32'h0);
    check(rdata, {24'h0, irq, 7'h0});
    ahb(IDX_STATUS, 1'b0, 32'h0);
    check(rdata, {29'h0, fmt, !irq && on && fmt != FMT_RESERVED});
    rx <= 16'($urandom);
    tx <= 16'($urandom);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (2 * PWM_PERIOD) @(posedge clk);
    d = highs;
    repeat (3 * PWM_PERIOD) @(posedge clk);
    d = highs - d;
    e = lvl(rx, tx, ra, ta);
    e = (fmt == FMT_DELTA_SIGMA) ? e * 3 * PWM_PERIOD / 65536 : 3 * ((e * PWM_PERIOD) >> 16);
    if (irq || !on || fmt == FMT_RESERVED) e = 0;
    check({31'h0, d + 3 >= e && d <= e + 3}, 32'h1);
  endtask
  initial
  begin
    void'($urandom(77));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    ahb(IDX_RX_ATT, 1'b0, 32'h0);
    check(rdata, {24'h0, ATT_RESET});
    ahb(IDX_TX_ATT, 1'b0, 32'h0);
    check(rdata, {24'h0, ATT_RESET});
    ahb(8'h30, 1'b0, 32'h0);
    check(rdata, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      r = $urandom;
      ahb(i[0] ? IDX_TX_ATT : IDX_RX_ATT, 1'b1, r);
      ahb(i[0] ? IDX_TX_ATT : IDX_RX_ATT, 1'b0, 32'h0);
      check(rdata, {24'h0, r[7:0]});
    end
    for (int f = 0; f < 4; f++) run(1'b0, 1'b1, f[1:0], 8'($urandom), 8'($urandom));
    run(1'b0, 1'b1, FMT_RZ_PWM, 8'h00, 8'h00);
    run(1'b0, 1'b1, FMT_BAL_PWM, 8'hff, 8'h00);
    run(1'b0, 1'b0, FMT_DELTA_SIGMA, 8'hff, 8'hff);
    run(1'b1, 1'b1, FMT_DELTA_SIGMA, 8'hff, 8'hff);
    run(1'b0, 1'b1, FMT_RZ_PWM, 8'h80, 8'h00);
    // A reset in mid-run must drop the pin and every setting, whatever was playing.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, pin}, 32'h0);
    check(hrdata, 32'h0);
    rst_n <= 1'b1;
    ahb(IDX_RX_ATT, 1'b0, 32'h0);
    check(rdata, {24'h0, ATT_RESET});
    ahb(IDX_STATUS, 1'b0, 32'h0);
    check(rdata, 32'h0);
    end_sim;
  end
  // The whole run needs about 15000 clocks; twice that means a hang.
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim;
  end
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
endmodule // call_progress_pwm_output_tb
